// ===== logic/pcint_defs.vh
// constants for the pin-change interrupt block
`ifndef PCINT_DEFS_VH
`define PCINT_DEFS_VH
`define PCINT_OFS_RISE_A   8'h00
`define PCINT_OFS_RISE_B   8'h04
`define PCINT_OFS_RISE_C   8'h08
`define PCINT_OFS_RISE_E   8'h0C
`define PCINT_OFS_FALL_A   8'h10
`define PCINT_OFS_FALL_B   8'h14
`define PCINT_OFS_FALL_C   8'h18
`define PCINT_OFS_FALL_E   8'h1C
`define PCINT_OFS_FLAG_A   8'h20
`define PCINT_OFS_FLAG_B   8'h24
`define PCINT_OFS_FLAG_C   8'h28
`define PCINT_OFS_FLAG_E   8'h2C
`define PCINT_OFS_CTRL     8'h30
`define PCINT_OFS_IRQ_STAT 8'h34
`define PCINT_OFS_IRQ_MASK 8'h38
`define PCINT_CTRL_MEN_BIT 0
`define PCINT_E_PIN        3
`define PCINT_NPIN         25
`define PCINT_RESP_OKAY    2'b00
`define PCINT_RESP_SLVERR  2'b10
`endif

// ===== logic/pcint_edge.v
// synchroniser and rise/fall detector for one group of pins
module pcint_edge #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] pin_in,
  input  wire [W-1:0] rise_en,
  input  wire [W-1:0] fall_en,
  output wire [W-1:0] edge_hit
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;

  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
      prev_ff <= {W{1'b0}};
    end else begin
      meta_ff <= pin_in;  // see R14
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // see R4 see R5 see R6 see R14
  assign edge_hit = (rise_en & sync_ff & ~prev_ff) | (fall_en & ~sync_ff & prev_ff);
endmodule // pcint_edge

// ===== logic/pcint_top.v
// pin-change interrupt block with AXI4-Lite register slave
// Notes on behaviour
// R1: ports a, b, c and port e pin three
// R2: each pin configured independently
// R3: master enable off still sets flags
// R4: rise detector gated by rise enable bit
// R5: fall detector gated by fall enable bit
// R6: both enables detect either edge
// R7: enabled edge sets flag, irq if enabled
// R8: summary flag is or of all flags
// R9: writing zero clears a flag
// R10: edge during flag write wins
// R11: software clears with masked and writes
// R12: change wakes from sleep when enabled
// R13: sleep edges recorded before wake completes
// R14: pins synchronised, edges by sample compare
//
// The AXI4-Lite register port and the address map were decided locally.
`include "pcint_defs.vh"
module pcint_top (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  port_a_pin,
  input  wire [7:0]  port_b_pin,
  input  wire [7:0]  port_c_pin,
  input  wire        port_e_pin_three,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        change_summary_flag,
  output wire        change_irq,
  output wire        wake_req,
  output wire        irq
);
  ////////////////////////////////////////////////////////////////////////////
  reg  [`PCINT_NPIN-1:0] rise_edge_enable_ff;
  reg  [`PCINT_NPIN-1:0] fall_edge_enable_ff;
  reg  [`PCINT_NPIN-1:0] flag_ff;
  reg                    change_irq_master_enable_ff;
  reg  [0:0]             irq_stat_ff;
  reg  [0:0]             irq_mask_ff;
  reg                    aw_full_ff;
  reg  [7:0]             aw_addr_ff;
  reg                    w_full_ff;
  reg  [31:0]            w_data_ff;
  reg  [3:0]             w_strb_ff;
  reg                    bvalid_ff;
  reg  [1:0]             bresp_ff;
  reg                    rvalid_ff;
  reg  [31:0]            rdata_ff;
  reg  [1:0]             rresp_ff;
  reg                    summ_prev_ff;
  wire [`PCINT_NPIN-1:0] edge_hit;
  wire [`PCINT_NPIN-1:0] pins;

  // flat pin vector: a[7:0], b[15:8], c[23:16], e3 at 24
  assign pins = {port_e_pin_three, port_c_pin, port_b_pin, port_a_pin};  // see R1

  pcint_edge #(
    .W(`PCINT_NPIN)
  ) u_edge (
    .clk      (clk),
    .rst      (rst),
    .pin_in   (pins),
    .rise_en  (rise_edge_enable_ff),
    .fall_en  (fall_edge_enable_ff),
    .edge_hit (edge_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  wire do_wr = aw_full_ff && w_full_ff && !bvalid_ff;
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready  = !w_full_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // merge an 8-bit field of a 32-bit word under byte lane 0
  function [7:0] lane0;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      lane0 = strb[0] ? data[7:0] : old;
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'b00) && (a <= `PCINT_OFS_IRQ_MASK);
    end
  endfunction

  wire [7:0] wa = aw_addr_ff;
  wire [7:0] ws = {8{w_strb_ff[0]}};
  wire [7:0] wd = w_data_ff[7:0];

  // flags: written bits take the written value, new edges then force set
  reg [`PCINT_NPIN-1:0] nxt_flag;
  always @* begin
    nxt_flag = flag_ff;
    if (do_wr) begin
      case (wa)
        `PCINT_OFS_FLAG_A: nxt_flag[7:0]   = (flag_ff[7:0] & ~ws) | (wd & ws);  // see R9
        `PCINT_OFS_FLAG_B: nxt_flag[15:8]  = (flag_ff[15:8] & ~ws) | (wd & ws);
        `PCINT_OFS_FLAG_C: nxt_flag[23:16] = (flag_ff[23:16] & ~ws) | (wd & ws);
        `PCINT_OFS_FLAG_E: begin
          if (w_strb_ff[0])
            nxt_flag[24] = w_data_ff[`PCINT_E_PIN];
        end
        default: nxt_flag = flag_ff;
      endcase
    end
    nxt_flag = nxt_flag | edge_hit;  // see R7 see R10 see R3 see R13
  end

  wire summary = |flag_ff;  // see R8
  assign change_summary_flag = summary;
  assign change_irq = summary && change_irq_master_enable_ff;  // see R3 see R7
  // wake is combinational so it works with no bus activity during sleep
  assign wake_req   = change_irq;  // see R12
  assign irq        = |(irq_stat_ff & irq_mask_ff);

  always @(posedge clk) begin
    if (rst) begin
      rise_edge_enable_ff         <= {`PCINT_NPIN{1'b0}};
      fall_edge_enable_ff         <= {`PCINT_NPIN{1'b0}};
      flag_ff                     <= {`PCINT_NPIN{1'b0}};
      change_irq_master_enable_ff <= 1'b0;
      irq_stat_ff                 <= 1'b0;
      irq_mask_ff                 <= 1'b0;
      aw_full_ff                  <= 1'b0;
      aw_addr_ff                  <= 8'h00;
      w_full_ff                   <= 1'b0;
      w_data_ff                   <= 32'h00000000;
      w_strb_ff                   <= 4'h0;
      bvalid_ff                   <= 1'b0;
      bresp_ff                    <= `PCINT_RESP_OKAY;
      summ_prev_ff                <= 1'b0;
    end else begin
      flag_ff      <= nxt_flag;
      summ_prev_ff <= summary;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
      // status event: summary rises; set wins over write-one clear
      if (summary && !summ_prev_ff)
        irq_stat_ff <= 1'b1;
      else if (do_wr && wa == `PCINT_OFS_IRQ_STAT && w_strb_ff[0] && w_data_ff[0])
        irq_stat_ff <= 1'b0;
      if (do_wr) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= addr_ok(wa) ? `PCINT_RESP_OKAY : `PCINT_RESP_SLVERR;
        case (wa)
          `PCINT_OFS_RISE_A: rise_edge_enable_ff[7:0]   <=
                               lane0(rise_edge_enable_ff[7:0], w_data_ff, w_strb_ff);  // see R2
          `PCINT_OFS_RISE_B: rise_edge_enable_ff[15:8]  <=
                               lane0(rise_edge_enable_ff[15:8], w_data_ff, w_strb_ff);
          `PCINT_OFS_RISE_C: rise_edge_enable_ff[23:16] <=
                               lane0(rise_edge_enable_ff[23:16], w_data_ff, w_strb_ff);
          `PCINT_OFS_RISE_E: begin
            if (w_strb_ff[0])
              rise_edge_enable_ff[24] <= w_data_ff[`PCINT_E_PIN];
          end
          `PCINT_OFS_FALL_A: fall_edge_enable_ff[7:0]   <=
                               lane0(fall_edge_enable_ff[7:0], w_data_ff, w_strb_ff);
          `PCINT_OFS_FALL_B: fall_edge_enable_ff[15:8]  <=
                               lane0(fall_edge_enable_ff[15:8], w_data_ff, w_strb_ff);
          `PCINT_OFS_FALL_C: fall_edge_enable_ff[23:16] <=
                               lane0(fall_edge_enable_ff[23:16], w_data_ff, w_strb_ff);
          `PCINT_OFS_FALL_E: begin
            if (w_strb_ff[0])
              fall_edge_enable_ff[24] <= w_data_ff[`PCINT_E_PIN];
          end
          `PCINT_OFS_CTRL: begin
            if (w_strb_ff[0])
              change_irq_master_enable_ff <= w_data_ff[`PCINT_CTRL_MEN_BIT];
          end
          `PCINT_OFS_IRQ_MASK: begin
            if (w_strb_ff[0])
              irq_mask_ff <= w_data_ff[0:0];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle after address taken
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `PCINT_OFS_RISE_A:   rd_mux[7:0] = rise_edge_enable_ff[7:0];
      `PCINT_OFS_RISE_B:   rd_mux[7:0] = rise_edge_enable_ff[15:8];
      `PCINT_OFS_RISE_C:   rd_mux[7:0] = rise_edge_enable_ff[23:16];
      `PCINT_OFS_RISE_E:   rd_mux[`PCINT_E_PIN] = rise_edge_enable_ff[24];
      `PCINT_OFS_FALL_A:   rd_mux[7:0] = fall_edge_enable_ff[7:0];
      `PCINT_OFS_FALL_B:   rd_mux[7:0] = fall_edge_enable_ff[15:8];
      `PCINT_OFS_FALL_C:   rd_mux[7:0] = fall_edge_enable_ff[23:16];
      `PCINT_OFS_FALL_E:   rd_mux[`PCINT_E_PIN] = fall_edge_enable_ff[24];
      `PCINT_OFS_FLAG_A:   rd_mux[7:0] = flag_ff[7:0];
      `PCINT_OFS_FLAG_B:   rd_mux[7:0] = flag_ff[15:8];
      `PCINT_OFS_FLAG_C:   rd_mux[7:0] = flag_ff[23:16];
      `PCINT_OFS_FLAG_E:   rd_mux[`PCINT_E_PIN] = flag_ff[24];
      `PCINT_OFS_CTRL: begin
        rd_mux[`PCINT_CTRL_MEN_BIT] = change_irq_master_enable_ff;
        rd_mux[1] = summary;
      end
      `PCINT_OFS_IRQ_STAT: rd_mux[0] = irq_stat_ff[0];
      `PCINT_OFS_IRQ_MASK: rd_mux[0] = irq_mask_ff[0];
      default:             rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `PCINT_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= addr_ok(s_axi_araddr) ? `PCINT_RESP_OKAY : `PCINT_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule // pcint_top

// ===== sim/pcint_assertions.sv
// concurrent checks on the pin-change block ports
module pcint_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic change_summary_flag,
  input wire logic change_irq,
  input wire logic wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_wake_equal: assert property (wake_req == change_irq)
    else $error("wake request differs from change interrupt");
  a_irq_summary: assert property (change_irq |-> change_summary_flag)
    else $error("change interrupt without summary flag");
  a_clear_by_write: assert property ($fell(change_summary_flag) |-> $rose(s_axi_bvalid))
    else $error("summary flag fell without a write");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted during response");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule // pcint_chk

bind pcint_top pcint_chk i_pcint_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .change_summary_flag, .change_irq, .wake_req);

// ===== sim/pcint_pins.sv
// external levels on the monitored pins
module pcint_pins (
  input  wire logic        clk,
  input  wire logic [24:0] want,
  output logic      [24:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 25'h0;
  // levels held at least one cycle, so pulses are wide enough
  always @(posedge clk) begin
    pins <= want;
  end
endmodule // pcint_pins

// ===== sim/tb.sv
// self-checking bench for the pin-change block
`include "pcint_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0, rst = 1'h1;
  logic [24:0] want = 25'h0, pins, fl = 25'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, men = 1'h0, st = 1'h0, mk = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, r, f, v, m;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         change_summary_flag, change_irq, wake_req, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  logic [37:0] q[$];
  logic [1:0]  bq[$];
  int          fails = 0, compares = 0, cyc = 0;

  pcint_pins i_pcint_pins (.clk, .want, .pins);
  pcint_top i_pcint_top (.clk, .rst, .port_a_pin(pins[7:0]), .port_b_pin(pins[15:8]),
    .port_c_pin(pins[23:16]), .port_e_pin_three(pins[24]), .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .change_summary_flag, .change_irq, .wake_req,
    .irq);

  always #25 clk = ~clk;
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rs = `PCINT_RESP_OKAY);
    bq.push_back(rs);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h0;
    end while (s_axi_bready);
  endtask

  // note carries expected port levels, response and data
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    q.push_back({|fl, (|fl) & men, (|fl) & men, st & mk, rs, d});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h0;
    end while (s_axi_rready);
  endtask

  task automatic setp(input int g, input logic [7:0] x);
    if (g < 3) want[g*8+:8] <= x;
    else want[24] <= x[3];
  endtask

  function automatic logic [31:0] gv(input int g);
    gv = (g < 3) ? {24'h0, fl[g*8+:8]} : {28'h0, fl[24], 3'h0};
  endfunction

  task automatic results();
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && q.size() > 0) begin
      compares++;
      if ({change_summary_flag, change_irq, wake_req, irq, s_axi_rresp, s_axi_rdata}
          !== q.pop_front()) begin
        fails++;
        $display("Error %0t read or output mismatch", $time);
      end
    end
  end

  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      compares++;
      if (s_axi_bresp !== bq.pop_front()) begin
        fails++;
        $display("Error %0t write response mismatch", $time);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  initial begin
    int g;
    void'($urandom(32'h63dd));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd(`PCINT_OFS_CTRL, 32'h0, `PCINT_RESP_OKAY);
    rd(8'h3C, 32'h0, `PCINT_RESP_SLVERR);
    for (g = 0; g < 4; g++) begin
      m = (g == 3) ? 8'h08 : 8'hFF;
      r = 8'($urandom | 32'hF) & m;
      f = 8'($urandom) & m;
      v = 8'($urandom | 32'hF) & m;
      wr(8'h00 + 8'(4 * g), {24'h0, r});
      wr(8'h10 + 8'(4 * g), {24'h0, f});
      setp(g, v);
      repeat (6) @(posedge clk);
      setp(g, 8'h0);
      repeat (6) @(posedge clk);
      if (g < 3) fl[g*8+:8] = v & (r | f);
      else fl[24] = v[3] & (r[3] | f[3]);
      st = st | (|fl);
      rd(8'h20 + 8'(4 * g), gv(g), `PCINT_RESP_OKAY);
    end
    rd(`PCINT_OFS_CTRL, 32'h2, `PCINT_RESP_OKAY);
    wr(`PCINT_OFS_CTRL, 32'h1);
    men = 1'h1;
    wr(`PCINT_OFS_IRQ_MASK, 32'h1);
    mk = 1'h1;
    rd(`PCINT_OFS_CTRL, 32'h3, `PCINT_RESP_OKAY);
    for (g = 0; g < 4; g++) wr(8'h20 + 8'(4 * g), gv(g) & ~gv(g));
    fl = 25'h0;
    rd(`PCINT_OFS_FLAG_A, 32'h0, `PCINT_RESP_OKAY);
    wr(`PCINT_OFS_IRQ_STAT, 32'h1);
    st = 1'h0;
    rd(`PCINT_OFS_IRQ_STAT, 32'h0, `PCINT_RESP_OKAY);
    wr(`PCINT_OFS_RISE_A, 32'h2);
    want[1] <= 1'h1;
    // edge reaches the flag logic in the cycle the write is applied
    repeat (1) @(posedge clk);
    wr(`PCINT_OFS_FLAG_A, 32'h0);
    fl[1] = 1'h1;
    st = 1'h1;
    rd(`PCINT_OFS_FLAG_A, 32'h2, `PCINT_RESP_OKAY);
    // lane 0 strobe low: the write must leave the master enable set
    s_axi_wstrb <= 4'hE;
    wr(`PCINT_OFS_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(`PCINT_OFS_CTRL, 32'h3, `PCINT_RESP_OKAY);
    wr(8'h3C, 32'h1, `PCINT_RESP_SLVERR);
    rd(`PCINT_OFS_IRQ_STAT, 32'h1, `PCINT_RESP_OKAY);
    repeat (4) @(posedge clk);
    results();
  end
endmodule // tb
